// ==== rtl/pvic_irq_ctrl.sv ====
// Vectored prioritized interrupt controller with core dispatch sequencing
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Fixed priorities 0 to 25; vector is four times the priority
// - Priorities 0-12: reset, POR, line0, SPI tx/rx, ports, line1, USB
// - 13 ms timer, 14 interval, 17 wrap, 18 line2, 20 port2, 25 sleep
// - A condition sets the posted flag until taken or cleared
// - Pending is posted AND enable bit; reset slot is pending when posted alone
// - Encoder picks highest pending; taken only with global enable set
// - Clearing an enable bit neither clears nor stops posting
// - Request rises on posting, enable update, or global enable rising
// - Port sources post on rising edges
// - Wait for instruction end, then 13 dispatch cycles
// - Push program counter high, low, then flag register
// - Then clear the flag register, dropping global enable
// - Program counter high zero, low byte gets the vector
// - Return restores flags, re-enabling requests
// - Pending requests dispatch again right after a return
// - Global enable set inside a service routine allows nesting
// - Latency: instruction rest plus 13 plus 7 jump cycles
// - Reading a flag register shows one posted bit per source
// - Write 0 clears a flag with soft post off; write 1 posts when soft post enabled
// - Flag register 0 layout: port1, sleep, line1, port0, SPI, line0, POR
// - Soft post enable is bit 7 of enable register three
// - Each enable bit acts alone on its own source
module pvic_irq_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [pvic_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pvic_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pvic_pkg::DATA_W-1:0] reg_rdata_o,
  // Interrupt sources
  input wire logic [pvic_pkg::NUM_PRIO-1:0] source_event_i,
  input wire logic [2:0] gpio_port_level_i,
  // Core side
  input wire logic global_irq_enable_i,
  input wire logic instr_done_i,
  output logic irq_req_o,
  output logic stack_push_o,
  output logic [1:0] stack_push_sel_o,
  output logic flags_clear_o,
  output logic vector_load_o,
  output logic [7:0] program_counter_high_o,
  output logic [7:0] program_counter_low_o,
  output logic isr_start_o
);
  import pvic_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [NUM_PRIO-1:0] posted;
  logic [NUM_PRIO-1:0] next_posted;
  logic [NUM_PRIO-1:0] source_enable;
  logic [NUM_PRIO-1:0] next_source_enable;
  logic soft_post_enable;
  logic next_soft_post_enable;
  logic [2:0] port_prev;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  pvic_state_t state;
  pvic_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [PRIO_W-1:0] taken;
  logic [PRIO_W-1:0] next_taken;
  logic [7:0] program_counter_low;
  logic [7:0] next_pcl;
  logic [7:0] program_counter_high;
  logic [7:0] next_pch;
  logic [NUM_PRIO-1:0] set_vec;
  logic [NUM_PRIO-1:0] clr_vec;
  logic [2:0] port_edge;
  logic ack;
  logic flags_wr;
  logic [1:0] flags_grp;
  logic enable_wr;
  logic [1:0] enable_grp;

  pvic_enc_if enc_bus ();

  pvic_prio_enc u_enc (
    .enc (enc_bus.enc)
  );

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    flags_wr = 1'b0;
    flags_grp = 2'h0;
    enable_wr = 1'b0;
    enable_grp = 2'h0;
    unique case (reg_addr_i)
      ADDR_FLAGS_0: begin
        flags_wr = reg_wr_i;
        flags_grp = 2'h0;
      end
      ADDR_FLAGS_1: begin
        flags_wr = reg_wr_i;
        flags_grp = 2'h1;
      end
      ADDR_FLAGS_2: begin
        flags_wr = reg_wr_i;
        flags_grp = 2'h2;
      end
      ADDR_ENABLE_0: begin
        enable_wr = reg_wr_i;
        enable_grp = 2'h0;
      end
      ADDR_ENABLE_1: begin
        enable_wr = reg_wr_i;
        enable_grp = 2'h1;
      end
      ADDR_ENABLE_2: begin
        enable_wr = reg_wr_i;
        enable_grp = 2'h2;
      end
      default: begin
        flags_wr = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Posted flags
  // ****************************************
  // Ports see level inputs; only a rising edge posts
  assign port_edge = gpio_port_level_i & ~port_prev;
  assign ack = vector_load_o;

  always_comb begin
    logic [4:0] p;
    p = PRIO_NONE;
    set_vec = source_event_i;
    set_vec[PRIO_PORT0] = port_edge[0];
    set_vec[PRIO_PORT1] = port_edge[1];
    set_vec[PRIO_PORT2] = port_edge[2];
    clr_vec = '0;
    if (flags_wr) begin
      for (int b = 0; b < DATA_W; b++) begin
        p = pvic_prio_of(flags_grp, 3'(b));
        if (p != PRIO_NONE) begin
          // Meaning of a written bit flips with soft post enable
          if (soft_post_enable && reg_wdata_i[b]) begin
            set_vec[p] = 1'b1;
          end
          if (!soft_post_enable && !reg_wdata_i[b]) begin
            clr_vec[p] = 1'b1;
          end
        end
      end
    end
    if (ack) begin
      clr_vec[taken] = 1'b1;
    end
    // Set after clear so a same-cycle condition is never lost
    next_posted = ((posted & ~clr_vec) | set_vec) &
                  VALID_PRIO;
  end

  // ****************************************
  // Enable registers
  // ****************************************
  always_comb begin
    logic [4:0] p;
    p = PRIO_NONE;
    next_source_enable = source_enable;
    next_soft_post_enable = soft_post_enable;
    if (enable_wr) begin
      for (int b = 0; b < DATA_W; b++) begin
        p = pvic_prio_of(enable_grp, 3'(b));
        if (p != PRIO_NONE) begin
          next_source_enable[p] = reg_wdata_i[b];
        end
      end
    end
    if (reg_wr_i && reg_addr_i == ADDR_ENABLE_3) begin
      next_soft_post_enable = reg_wdata_i[SOFT_POST_BIT];
    end
  end

  // Masking gates pending only, never the flag itself
  always_comb begin
    enc_bus.pending = posted & source_enable & VALID_PRIO;
    // Reset slot has no enable bit and is always eligible
    enc_bus.pending[PRIO_RESET] = posted[PRIO_RESET];
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    logic [4:0] p;
    p = PRIO_NONE;
    next_rdata = REG_RESET;
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_ENABLE_3) begin
        next_rdata[SOFT_POST_BIT] = soft_post_enable;
      end
      for (int b = 0; b < DATA_W; b++) begin
        if (reg_addr_i == ADDR_FLAGS_0 || reg_addr_i == ADDR_FLAGS_1 ||
            reg_addr_i == ADDR_FLAGS_2) begin
          p = pvic_prio_of(2'(reg_addr_i - ADDR_FLAGS_0), 3'(b));
          if (p != PRIO_NONE) begin
            next_rdata[b] = posted[p];
          end
        end
        if (reg_addr_i == ADDR_ENABLE_0 || reg_addr_i == ADDR_ENABLE_1 ||
            reg_addr_i == ADDR_ENABLE_2) begin
          p = pvic_prio_of(enable_grp, 3'(b));
          if (p != PRIO_NONE) begin
            next_rdata[b] = source_enable[p];
          end
        end
      end
    end
  end

  // ****************************************
  // Dispatch sequencer
  // ****************************************
  // Request is live in idle and wait; covers all three activation cases
  assign irq_req_o = (state == PVIC_IDLE || state == PVIC_WAIT) &&
                     global_irq_enable_i &&
                     enc_bus.valid;
  assign stack_push_o = (state == PVIC_DISP) && (cnt == STEP_PUSH_PCH ||
                        cnt == STEP_PUSH_PCL || cnt == STEP_PUSH_FLAGS);
  assign flags_clear_o = (state == PVIC_DISP) &&
                         cnt == STEP_FLAGS_CLEAR;
  assign vector_load_o = (state == PVIC_DISP) &&
                         cnt == DISPATCH_CYCLES;
  assign isr_start_o = (state == PVIC_JUMP) &&
                       cnt == LONG_JUMP_CYCLES;

  always_comb begin
    unique case (cnt)
      STEP_PUSH_PCL: stack_push_sel_o = PUSH_PCL;
      STEP_PUSH_FLAGS: stack_push_sel_o = PUSH_FLAGS;
      default: stack_push_sel_o = PUSH_PCH;
    endcase
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_taken = taken;
    next_pcl = program_counter_low;
    next_pch = program_counter_high;
    unique case (state)
      PVIC_IDLE: begin
        if (irq_req_o) begin
          next_state = PVIC_WAIT;
        end
      end
      PVIC_WAIT: begin
        if (!irq_req_o) begin
          next_state = PVIC_IDLE;
        end else if (instr_done_i) begin
          // Winner is frozen here so the vector stays stable
          next_state = PVIC_DISP;
          next_cnt = 4'h1;
          next_taken = enc_bus.index;
          next_pcl = {1'b0, enc_bus.index, 2'b00};
        end
      end
      PVIC_DISP: begin
        next_cnt = cnt + 4'h1;
        if (cnt == DISPATCH_CYCLES) begin
          next_state = PVIC_JUMP;
          next_cnt = 4'h1;
          next_pch = PC_HIGH_VECTOR;
        end
      end
      PVIC_JUMP: begin
        next_cnt = cnt + 4'h1;
        if (cnt == LONG_JUMP_CYCLES) begin
          next_state = PVIC_IDLE;
          next_cnt = 4'h0;
        end
      end
      default: begin
        next_state = PVIC_IDLE;
        next_cnt = 4'h0;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      posted <= FLAGS_RESET;
      source_enable <= ENABLE_RESET;
      soft_post_enable <= 1'b0;
      port_prev <= 3'h0;
      rdata <= REG_RESET;
      state <= PVIC_IDLE;
      cnt <= 4'h0;
      taken <= 5'h00;
      program_counter_low <= 8'h00;
      program_counter_high <= 8'h00;
    end else begin
      posted <= next_posted;
      source_enable <= next_source_enable;
      soft_post_enable <= next_soft_post_enable;
      port_prev <= gpio_port_level_i;
      rdata <= next_rdata;
      state <= next_state;
      cnt <= next_cnt;
      taken <= next_taken;
      program_counter_low <= next_pcl;
      program_counter_high <= next_pch;
    end
  end

  assign reg_rdata_o = rdata;
  assign program_counter_low_o = program_counter_low;
  assign program_counter_high_o = program_counter_high;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence pushes_s;
    stack_push_o && stack_push_sel_o == PUSH_PCH ##1
    stack_push_o && stack_push_sel_o == PUSH_PCL ##1
    stack_push_o && stack_push_sel_o == PUSH_FLAGS;
  endsequence

  sequence clear_s;
    flags_clear_o && !stack_push_o;
  endsequence

  reserved_never_post_a: assert property (
    (posted & ~VALID_PRIO) == '0)
    else $error("reserved slot posted");

  set_wins_a: assert property (
    |set_vec |=> (posted & $past(set_vec & VALID_PRIO)) ==
                 $past(set_vec & VALID_PRIO))
    else $error("new condition lost to a clear");

  request_gate_a: assert property (
    irq_req_o |-> global_irq_enable_i &&
    (posted[PRIO_RESET] || |(posted & source_enable)))
    else $error("request without enabled pending source");

  mask_keeps_flag_a: assert property (
    enable_wr && !ack |=> (posted & $past(posted)) == $past(posted))
    else $error("enable write cleared a posted flag");

  push_order_a: assert property (
    state == PVIC_DISP && cnt == STEP_PUSH_PCH |-> pushes_s ##1 clear_s)
    else $error("stack push order wrong");

  dispatch_length_a: assert property (
    state == PVIC_WAIT && instr_done_i && irq_req_o |=>
    !vector_load_o [*8] ##1 !vector_load_o [*4] ##1 vector_load_o)
    else $error("dispatch not 13 cycles");

  jump_latency_a: assert property (
    vector_load_o |-> ##7 isr_start_o)
    else $error("service start not 7 cycles after vector");

  vector_value_a: assert property (
    vector_load_o |-> program_counter_low_o == {1'b0, taken, 2'b00} &&
    VALID_PRIO[taken] ##1 program_counter_high_o == PC_HIGH_VECTOR)
    else $error("vector not four times priority");

  ack_clears_taken_a: assert property (
    vector_load_o && !set_vec[taken] |=> !posted[$past(taken)])
    else $error("taken flag not cleared");

  soft_zero_ignored_a: assert property (
    flags_wr && soft_post_enable && !ack |=>
    (posted & $past(posted)) == $past(posted))
    else $error("zero write cleared under soft post");

endmodule
`default_nettype wire

// ==== rtl/pvic_pkg.sv ====
// Constants, types and source map of the vectored interrupt controller
package pvic_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int NUM_PRIO = 26;
  localparam int PRIO_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_FLAGS_0 = 8'hda;
  localparam logic [7:0] ADDR_FLAGS_1 = 8'hdb;
  localparam logic [7:0] ADDR_FLAGS_2 = 8'hdc;
  localparam logic [7:0] ADDR_ENABLE_3 = 8'hde;
  localparam logic [7:0] ADDR_ENABLE_2 = 8'hdf;
  localparam logic [7:0] ADDR_ENABLE_0 = 8'he0;
  localparam logic [7:0] ADDR_ENABLE_1 = 8'he1;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int SOFT_POST_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [25:0] FLAGS_RESET = 26'h0000000;
  localparam logic [25:0] ENABLE_RESET = 26'h0000000;
  // Slots 15, 16, 19 and 21 to 24 are reserved
  localparam logic [25:0] VALID_PRIO = 26'h2167fff;
  localparam logic [4:0] PRIO_NONE = 5'h1f;
  localparam logic [4:0] PRIO_RESET = 5'h00;
  localparam logic [4:0] PRIO_PORT0 = 5'h05;
  localparam logic [4:0] PRIO_PORT1 = 5'h06;
  localparam logic [4:0] PRIO_PORT2 = 5'h14;

  // ****************************************
  // Dispatch timing and stack pushes
  // ****************************************
  localparam logic [3:0] DISPATCH_CYCLES = 4'hd;
  localparam logic [3:0] LONG_JUMP_CYCLES = 4'h7;
  localparam logic [3:0] STEP_PUSH_PCH = 4'h1;
  localparam logic [3:0] STEP_PUSH_PCL = 4'h2;
  localparam logic [3:0] STEP_PUSH_FLAGS = 4'h3;
  localparam logic [3:0] STEP_FLAGS_CLEAR = 4'h4;
  localparam logic [1:0] PUSH_PCH = 2'h0;
  localparam logic [1:0] PUSH_PCL = 2'h1;
  localparam logic [1:0] PUSH_FLAGS = 2'h2;
  localparam logic [7:0] PC_HIGH_VECTOR = 8'h00;

  typedef enum logic [3:0] {
    PVIC_IDLE = 4'b0001,
    PVIC_WAIT = 4'b0010,
    PVIC_DISP = 4'b0100,
    PVIC_JUMP = 4'b1000
  } pvic_state_t;

  // Priority held by bit bit_idx of register group grp
  function automatic logic [4:0] pvic_prio_of(input logic [1:0] grp,
                                             input logic [2:0] bit_idx);
    logic [4:0] p;
    p = PRIO_NONE;
    unique case ({grp, bit_idx})
      5'h00: p = 5'h01;
      5'h01: p = 5'h02;
      5'h02: p = 5'h03;
      5'h03: p = 5'h04;
      5'h04: p = PRIO_PORT0;
      5'h05: p = 5'h07;
      5'h06: p = 5'h19;
      5'h07: p = PRIO_PORT1;
      5'h08: p = 5'h08;
      5'h09: p = 5'h09;
      5'h0a: p = 5'h0a;
      5'h0b: p = 5'h0b;
      5'h0c: p = 5'h0c;
      5'h0d: p = 5'h0d;
      5'h0e: p = 5'h0e;
      5'h11: p = 5'h11;
      5'h12: p = 5'h12;
      5'h14: p = PRIO_PORT2;
      default: p = PRIO_NONE;
    endcase
    return p;
  endfunction

endpackage

// ==== rtl/pvic_enc_if.sv ====
// Carrier between the controller and its priority encoder
`timescale 1ns/100ps
`default_nettype none
interface pvic_enc_if;
  import pvic_pkg::*;
  logic [NUM_PRIO-1:0] pending;
  logic valid;
  logic [PRIO_W-1:0] index;
  modport enc (input pending, output valid, output index);
  modport ctl (output pending, input valid, input index);
endinterface
`default_nettype wire

// ==== rtl/pvic_prio_enc.sv ====
// Fixed-priority encoder: lowest index wins
`timescale 1ns/100ps
`default_nettype none
module pvic_prio_enc (
  // Encoder side of the carrier
  pvic_enc_if.enc enc
);
  import pvic_pkg::*;

  always_comb begin
    enc.valid = |enc.pending;
    enc.index = PRIO_NONE;
    // Scan downward so the smallest pending number is left standing
    for (int i = NUM_PRIO - 1; i >= 0; i--) begin
      if (enc.pending[i]) begin
        enc.index = PRIO_W'(i);
      end
    end
  end

endmodule
`default_nettype wire

// ==== sim/pvic_core_model.sv ====
// Behavioural core model: instruction ends, global enable, return
`timescale 1ns/100ps
`default_nettype none
module pvic_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Bench controls
  input wire logic [3:0] instr_len_i,
  input wire logic gie_set_i,
  input wire logic ret_i,
  // Controller side
  input wire logic stack_push_i,
  input wire logic [1:0] stack_push_sel_i,
  input wire logic flags_clear_i,
  output logic global_irq_enable_o,
  output logic instr_done_o
);
  import pvic_pkg::*;
  logic [3:0] cnt;
  logic saved;
  // Length 1 gives a prompt core, larger values a slow one
  assign instr_done_o = (cnt >= instr_len_i - 4'h1);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt <= 4'h0;
      saved <= 1'b0;
      global_irq_enable_o <= 1'b0;
    end else begin
      cnt <= instr_done_o ? 4'h0 : cnt + 4'h1;
      // One stack level only; nesting depth is not modelled
      if (stack_push_i && stack_push_sel_i == PUSH_FLAGS) begin
        saved <= global_irq_enable_o;
      end
      if (flags_clear_i) begin
        global_irq_enable_o <= 1'b0;
      end else if (ret_i) begin
        global_irq_enable_o <= saved;
      end else if (gie_set_i) begin
        global_irq_enable_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_pvic_irq_ctrl.sv ====
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module tb_pvic_irq_ctrl;
  import pvic_pkg::*;
  // Reserved slots 15, 16, 19 and 21 to 24
  localparam logic [25:0] RSV = 26'h1e98000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [25:0] src = 26'h0000000;
  logic [2:0] gpio = 3'h0;
  logic [3:0] ilen = 4'h1;
  logic gie_set = 1'b0;
  logic ret = 1'b0;
  logic [7:0] rdata;
  logic [7:0] program_counter_high;
  logic [7:0] program_counter_low;
  logic [1:0] sel;
  logic global_irq_enable, idone, req, push, fclr, vload, isr;
  int err_total = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  pvic_irq_ctrl pvic_irq_ctrl_i (
    .clk_i(clk), .reset_n_i(reset_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .source_event_i(src), .gpio_port_level_i(gpio),
    .global_irq_enable_i(global_irq_enable), .instr_done_i(idone), .irq_req_o(req),
    .stack_push_o(push), .stack_push_sel_o(sel), .flags_clear_o(fclr),
    .vector_load_o(vload), .program_counter_high_o(program_counter_high),
    .program_counter_low_o(program_counter_low), .isr_start_o(isr)
  );

  pvic_core_model pvic_core_model_i (
    .clk_i(clk), .reset_n_i(reset_n), .instr_len_i(ilen),
    .gie_set_i(gie_set), .ret_i(ret), .stack_push_i(push),
    .stack_push_sel_i(sel), .flags_clear_i(fclr),
    .global_irq_enable_o(global_irq_enable), .instr_done_o(idone)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // Idle edge after the strobe keeps each strobe assignment unique
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk8(rdata, exp);
    @(posedge clk);
  endtask

  task automatic ev(input logic [25:0] v);
    src <= v;
    @(posedge clk);
    src <= 26'h0000000;
  endtask

  // Return (1) or global enable set (0) by the core model
  task automatic core_cmd(input logic r);
    ret <= r;
    gie_set <= !r;
    @(posedge clk);
    ret <= 1'b0;
    gie_set <= 1'b0;
  endtask

  // Exact: request seen in the cycle after the cause, push two later
  task automatic disp(input logic [7:0] v, input logic exact);
    int n;
    n = 0;
    @(negedge clk);
    chk1(req, 1'b1);
    if (exact) begin
      repeat (2) @(negedge clk);
    end else begin
      while (push !== 1'b1 && n < 16) begin
        @(negedge clk);
        n++;
      end
    end
    chk8(program_counter_low, v);
    chk8(program_counter_high, 8'h00);
    for (int k = 0; k < 20; k++) begin
      chk8({push, fclr, vload, isr},
           {k < 3, k == 3, k == 12, k == 19});
      if (k < 3) begin
        chk8({6'h00, sel}, k[7:0]);
      end
      @(negedge clk);
    end
    chk1(global_irq_enable, 1'b0);
    @(posedge clk);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] a [8] = '{ADDR_FLAGS_0, ADDR_FLAGS_1, ADDR_FLAGS_2,
      ADDR_ENABLE_0, ADDR_ENABLE_1, ADDR_ENABLE_2, ADDR_ENABLE_3, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd_chk(a[i], 8'h00);
    end
    chk1(req, 1'b0);
    $display("t_reset done");
  endtask

  task automatic t_soft;
    wr(ADDR_ENABLE_3, 8'h80);
    rd_chk(ADDR_ENABLE_3, 8'h80);
    wr(ADDR_FLAGS_0, 8'hff);
    wr(ADDR_FLAGS_2, 8'hff);
    wr(ADDR_FLAGS_0, 8'h00);
    rd_chk(ADDR_FLAGS_0, 8'hff);
    rd_chk(ADDR_FLAGS_2, 8'h16);
    wr(ADDR_ENABLE_3, 8'h00);
    wr(ADDR_FLAGS_0, 8'h7f);
    rd_chk(ADDR_FLAGS_0, 8'h7f);
    wr(ADDR_FLAGS_0, 8'h00);
    wr(ADDR_FLAGS_2, 8'h00);
    rd_chk(ADDR_FLAGS_2, 8'h00);
    src <= 26'h0000002;
    addr <= ADDR_FLAGS_0;
    wdata <= 8'h00;
    reg_wr <= 1'b1;
    @(posedge clk);
    src <= 26'h0000000;
    reg_wr <= 1'b0;
    @(posedge clk);
    rd_chk(ADDR_FLAGS_0, 8'h01);
    wr(ADDR_FLAGS_0, 8'h00);
    $display("t_soft done");
  endtask

  task automatic t_mask;
    core_cmd(1'b0);
    ev(26'h0000002);
    @(negedge clk);
    chk1(req, 1'b0);
    @(posedge clk);
    rd_chk(ADDR_FLAGS_0, 8'h01);
    wr(ADDR_ENABLE_0, 8'h01);
    disp(8'h04, 1'b0);
    ev(26'h0000002);
    @(negedge clk);
    chk1(req, 1'b0);
    @(posedge clk);
    ilen <= 4'h4;
    core_cmd(1'b0);
    disp(8'h04, 1'b0);
    ilen <= 4'h1;
    core_cmd(1'b1);
    @(negedge clk);
    chk1(global_irq_enable, 1'b1);
    @(posedge clk);
    $display("t_mask done");
  endtask

  task automatic t_vectors;
    wr(ADDR_ENABLE_0, 8'hff);
    wr(ADDR_ENABLE_1, 8'hff);
    wr(ADDR_ENABLE_2, 8'hff);
    rd_chk(ADDR_ENABLE_1, 8'h7f);
    rd_chk(ADDR_ENABLE_2, 8'h16);
    for (int p = 0; p < 26; p++) begin
      if (p != 5 && p != 6 && p != 20) begin
        ev(26'h0000001 << p);
        if (!RSV[p]) begin
          disp({p[5:0], 2'b00}, 1'b1);
          core_cmd(1'b1);
        end else begin
          @(negedge clk);
          chk1(req, 1'b0);
          @(posedge clk);
        end
      end
    end
    $display("t_vectors done");
  endtask

  task automatic t_prio;
    ev(26'h0000084);
    disp(8'h08, 1'b1);
    rd_chk(ADDR_FLAGS_0, 8'h20);
    core_cmd(1'b1);
    disp(8'h1c, 1'b1);
    rd_chk(ADDR_FLAGS_0, 8'h00);
    core_cmd(1'b1);
    $display("t_prio done");
  endtask

  task automatic t_port;
    wr(ADDR_ENABLE_0, 8'h00);
    wr(ADDR_ENABLE_2, 8'h00);
    gpio <= 3'h1;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_FLAGS_0, 8'h10);
    wr(ADDR_FLAGS_0, 8'h00);
    rd_chk(ADDR_FLAGS_0, 8'h00);
    gpio <= 3'h6;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_FLAGS_0, 8'h80);
    rd_chk(ADDR_FLAGS_2, 8'h10);
    $display("t_port done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_soft;
    t_mask;
    t_vectors;
    t_prio;
    t_port;
    test_done;
  end

  // Whole run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done;
  end
endmodule
`default_nettype wire
